// >>> hdl/pospls_pkg.sv
// constants, register map and types of the positioning pulse block
package pospls_pkg;
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
	localparam int unsigned MAX_OUT_HZ = 200_000;
	localparam int unsigned MID_HZ = 100_000;
	localparam int unsigned HI_FIXED_NS = 2_500;
	localparam int unsigned HI_FIXED_CYC = (HI_FIXED_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned PER_MIN_CYC = (CLK_HZ + MAX_OUT_HZ - 1) / MAX_OUT_HZ;
	localparam int unsigned CLR_MS = 20;
	localparam int unsigned CLR_CYC = CLR_MS * (CLK_HZ / 1000);
	localparam int unsigned PER_W = 25;
	localparam int unsigned FRQ_W = 18;
	localparam int unsigned GAP_W = 8;
	localparam int unsigned CLR_W = 20;
	localparam int unsigned ADDR_W = 12;
	// register offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_MAXSPD = 12'h004;
	localparam logic [11:0] OFS_JOGSPD = 12'h008;
	localparam logic [11:0] OFS_COUNT = 12'h00C;
	localparam logic [11:0] OFS_STAT = 12'h010;
	// control bits: stored
	localparam int unsigned CB_MANUAL = 0;
	localparam int unsigned CB_REVERSE = 1;
	localparam int unsigned CB_INTERP = 2;
	localparam int unsigned CB_STANDBY = 3;
	// control bits: write-one command relays
	localparam int unsigned CB_START = 8;
	localparam int unsigned CB_STOP = 9;
	localparam int unsigned CB_ZERO_RET = 10;
	localparam int unsigned CB_CLEAR = 11;
	// reset values
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [17:0] MAXSPD_RST = 18'h186A0;
	localparam logic [17:0] JOGSPD_RST = 18'h003E8;
	localparam logic [31:0] COUNT_RST = 32'h00000000;
	// synchronised input positions
	localparam int unsigned IN_READY = 0;
	localparam int unsigned IN_SVDONE = 1;
	localparam int unsigned IN_ZPHASE = 2;
	localparam int unsigned IN_ZRET = 3;
	localparam int unsigned IN_JOGF = 4;
	localparam int unsigned IN_JOGR = 5;
	localparam int unsigned IN_LIMF = 6;
	localparam int unsigned IN_LIMR = 7;
	localparam int unsigned IN_NEAR = 8;
	localparam int unsigned IN_W = 9;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// drive kinds
	localparam logic [1:0] KIND_COUNT = 2'h0;
	localparam logic [1:0] KIND_JOG = 2'h1;
	localparam logic [1:0] KIND_ZERO = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CHECK = 3'h1,
		ST_HIGH = 3'h3,
		ST_LOW = 3'h2,
		ST_DONE = 3'h6
	} pospls_state_t;
endpackage

// >>> hdl/pospls_sync.sv
// three-stage input synchroniser with two-stage agreement
module pospls_sync
	import pospls_pkg::*;
#(
	parameter int unsigned W = 1
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			dout <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					dout[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

// >>> hdl/pospls_top.sv
// positioning step pulse generator with input sampling and AXI4-Lite registers
// Contract
// - zero phase examined only after near point
// - near point sampled only during return
// - auto: jog/zero return only at standby
// - auto: command relay bits monitored like pins
// - step rate never above 200 kHz
// - deviation clear is one 20 ms pulse
// - waveform chosen from frequency and, in dual axis, from the CB_INTERP control bit
// - dual axis: interpolated drives use interpolation waveform to 100 kHz
// - dual axis up to 100 kHz: 50/50
// - dual axis above 100 kHz: high fixed 2.5 us
// - single axis: 50/50 up to 200 kHz
// - manual jog speed from jog speed register
module pospls_top
	import pospls_pkg::*;
#(
	parameter bit DUAL_AXIS = 1'b1,
	parameter int unsigned CLR_CYC_P = CLR_CYC
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic servo_ready_in,
	input wire logic servo_done_in,
	input wire logic zero_phase_in,
	input wire logic zero_return_request,
	input wire logic jog_forward_in,
	input wire logic jog_reverse_in,
	input wire logic forward_limit_in,
	input wire logic reverse_limit_in,
	input wire logic near_point_in,
	output logic forward_step_out,
	output logic reverse_step_out,
	output logic deviation_clear_out
);
	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	logic [IN_W-1:0] in_s;
	logic aw_full_q, w_full_q, do_wr;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [3:0] ctrl_q;
	logic [FRQ_W-1:0] max_speed_param, jog_speed_param;
	logic [31:0] count_q, remain_q;
	logic start_p_q, stop_p_q, zret_p_q, clr_p_q;
	pospls_state_t state_q;
	logic [1:0] kind_q;
	logic dir_q, stop_pend_q, dog_seen_q, zp_prev_q, zp_found_q, done_q, err_q, interp_q;
	logic [PER_W-1:0] per_q, hi_q, cnt_q;
	logic [FRQ_W-1:0] frq_q;
	logic [GAP_W-1:0] gap_q;
	logic [CLR_W-1:0] clr_cnt_q;
	logic manual_mode, accept_op, jog_any, zr_req, lim_dir, abort, cont;
	logic [FRQ_W-1:0] frq_d;
	logic [PER_W-1:0] per_d;

	pospls_sync #(.W(IN_W)) u_sync (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.din({near_point_in, reverse_limit_in, forward_limit_in, jog_reverse_in,
			jog_forward_in, zero_return_request, zero_phase_in, servo_done_in,
			servo_ready_in}),
		.dout(in_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// bus slave
	assign do_wr = aw_full_q && w_full_q && !s_axi_bvalid;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_q <= s_axi_awaddr;
				aw_full_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				w_full_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_q <= OFS_COUNT) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr)
				OFS_CTRL: s_axi_rdata <= {28'h0, ctrl_q};
				OFS_MAXSPD: s_axi_rdata <= {14'h0, max_speed_param};
				OFS_JOGSPD: s_axi_rdata <= {14'h0, jog_speed_param};
				OFS_COUNT: s_axi_rdata <= count_q;
				OFS_STAT: s_axi_rdata <= {7'h0, in_s, 10'h0, deviation_clear_out,
					zp_found_q, dog_seen_q, err_q, done_q, (state_q != ST_IDLE)};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers and command relays
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= CTRL_RST;
			max_speed_param <= MAXSPD_RST;
			jog_speed_param <= JOGSPD_RST;
			count_q <= COUNT_RST;
			start_p_q <= 1'b0;
			stop_p_q <= 1'b0;
			zret_p_q <= 1'b0;
			clr_p_q <= 1'b0;
		end else begin
			start_p_q <= 1'b0;
			stop_p_q <= 1'b0;
			zret_p_q <= 1'b0;
			clr_p_q <= 1'b0;
			if (do_wr) begin
				unique case (aw_addr_q)
					OFS_CTRL: begin
						ctrl_q <= 4'(merge({28'h0, ctrl_q}, w_data_q, w_strb_q));
						if (w_strb_q[1]) begin
							start_p_q <= w_data_q[CB_START];
							stop_p_q <= w_data_q[CB_STOP];
							zret_p_q <= w_data_q[CB_ZERO_RET];
							clr_p_q <= w_data_q[CB_CLEAR];
						end
					end
					OFS_MAXSPD: max_speed_param <=
						FRQ_W'(merge({14'h0, max_speed_param}, w_data_q, w_strb_q));
					OFS_JOGSPD: jog_speed_param <=
						FRQ_W'(merge({14'h0, jog_speed_param}, w_data_q, w_strb_q));
					OFS_COUNT: count_q <= merge(count_q, w_data_q, w_strb_q);
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// request gating and waveform selection
	assign manual_mode = ctrl_q[CB_MANUAL];
	assign accept_op = manual_mode || ctrl_q[CB_STANDBY];
	assign jog_any = in_s[IN_JOGF] || in_s[IN_JOGR];
	assign zr_req = (in_s[IN_ZRET] || zret_p_q) && accept_op;
	assign lim_dir = dir_q ? in_s[IN_LIMR] : in_s[IN_LIMF];
	assign abort = !in_s[IN_READY] || lim_dir || stop_pend_q || stop_p_q;

	always_comb begin
		frq_d = (kind_q == KIND_JOG) ? jog_speed_param : max_speed_param;
		if (frq_d == '0) begin
			frq_d = FRQ_W'(1);
		end
		if (frq_d > FRQ_W'(MAX_OUT_HZ)) begin
			frq_d = FRQ_W'(MAX_OUT_HZ);
		end
		if (DUAL_AXIS && interp_q && frq_d > FRQ_W'(MID_HZ)) begin
			frq_d = FRQ_W'(MID_HZ);
		end
		per_d = PER_W'(CLK_HZ / 32'(frq_d));
	end

	always_comb begin
		unique case (kind_q)
			KIND_JOG: cont = accept_op && (dir_q ? in_s[IN_JOGR] : in_s[IN_JOGF]);
			KIND_ZERO: cont = !zp_found_q;
			default: cont = remain_q != '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// drive sequencer
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
			kind_q <= KIND_COUNT;
			dir_q <= 1'b0;
			interp_q <= 1'b0;
			remain_q <= '0;
			per_q <= PER_W'(PER_MIN_CYC);
			hi_q <= '0;
			frq_q <= '0;
			cnt_q <= '0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			stop_pend_q <= 1'b0;
		end else begin
			if (stop_p_q && state_q != ST_IDLE) begin
				stop_pend_q <= 1'b1;
			end
			unique case (state_q)
				ST_IDLE: begin
					stop_pend_q <= 1'b0;
					interp_q <= ctrl_q[CB_INTERP];
					if (zr_req) begin
						kind_q <= KIND_ZERO;
						dir_q <= ctrl_q[CB_REVERSE];
						state_q <= ST_CHECK;
					end else if (jog_any && accept_op) begin
						kind_q <= KIND_JOG;
						dir_q <= !in_s[IN_JOGF];
						state_q <= ST_CHECK;
					end else if (start_p_q && !manual_mode) begin
						kind_q <= KIND_COUNT;
						dir_q <= ctrl_q[CB_REVERSE];
						remain_q <= count_q;
						state_q <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					frq_q <= frq_d;
					per_q <= per_d;
					if (DUAL_AXIS && !interp_q && frq_d > FRQ_W'(MID_HZ)) begin
						hi_q <= PER_W'(HI_FIXED_CYC);
					end else begin
						hi_q <= per_d >> 1;
					end
					cnt_q <= '0;
					done_q <= 1'b0;
					if (!in_s[IN_READY] || lim_dir || (kind_q == KIND_COUNT && remain_q == '0)) begin
						err_q <= !in_s[IN_READY] || lim_dir;
						state_q <= ST_IDLE;
					end else if (gap_q >= GAP_W'(PER_MIN_CYC - 1)) begin
						err_q <= 1'b0;
						state_q <= ST_HIGH;
						if (kind_q == KIND_COUNT) begin
							remain_q <= remain_q - 32'h1;
						end
					end
				end
				ST_HIGH: begin
					cnt_q <= cnt_q + PER_W'(1);
					if (cnt_q == hi_q - PER_W'(1)) begin
						cnt_q <= '0;
						state_q <= ST_LOW;
					end
				end
				ST_LOW: begin
					cnt_q <= cnt_q + PER_W'(1);
					if (cnt_q >= per_q - hi_q - PER_W'(1)) begin
						cnt_q <= '0;
						if (abort || !cont) begin
							err_q <= !in_s[IN_READY] || lim_dir;
							state_q <= ST_DONE;
						end else begin
							state_q <= ST_HIGH;
							if (kind_q == KIND_COUNT) begin
								remain_q <= remain_q - 32'h1;
							end
						end
					end
				end
				ST_DONE: begin
					if (in_s[IN_SVDONE]) begin
						done_q <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// near point and zero phase sampling
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dog_seen_q <= 1'b0;
			zp_prev_q <= 1'b0;
			zp_found_q <= 1'b0;
		end else begin
			zp_prev_q <= in_s[IN_ZPHASE];
			if (state_q == ST_IDLE) begin
				dog_seen_q <= 1'b0;
				zp_found_q <= 1'b0;
			end else if (kind_q == KIND_ZERO && in_s[IN_NEAR]) begin
				dog_seen_q <= 1'b1;
			end
			if (kind_q == KIND_ZERO && dog_seen_q && in_s[IN_ZPHASE] && !zp_prev_q &&
				(state_q == ST_HIGH || state_q == ST_LOW)) begin
				zp_found_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// step outputs, spacing and deviation clear
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			forward_step_out <= 1'b0;
			reverse_step_out <= 1'b0;
			gap_q <= '1;
		end else begin
			forward_step_out <= state_q == ST_HIGH && !dir_q;
			reverse_step_out <= state_q == ST_HIGH && dir_q;
			if (state_q == ST_HIGH && cnt_q == '0) begin
				gap_q <= '0;
			end else if (gap_q != '1) begin
				gap_q <= gap_q + GAP_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			deviation_clear_out <= 1'b0;
			clr_cnt_q <= '0;
		end else if (!deviation_clear_out) begin
			if (clr_p_q || (state_q == ST_DONE && in_s[IN_SVDONE] && kind_q == KIND_ZERO)) begin
				deviation_clear_out <= 1'b1;
				clr_cnt_q <= CLR_W'(CLR_CYC_P - 1);
			end
		end else if (clr_cnt_q == '0) begin
			deviation_clear_out <= 1'b0;
		end else begin
			clr_cnt_q <= clr_cnt_q - CLR_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	logic step_any, step_prev;
	logic [PER_W-1:0] hi_len, since_rise;
	logic [CLR_W-1:0] clr_len;
	assign step_any = forward_step_out || reverse_step_out;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			step_prev <= 1'b0;
			hi_len <= '0;
			since_rise <= '1;
			clr_len <= '0;
		end else begin
			step_prev <= step_any;
			hi_len <= step_any ? hi_len + PER_W'(1) : '0;
			since_rise <= (step_any && !step_prev) ? PER_W'(1) :
				(since_rise == '1 ? since_rise : since_rise + PER_W'(1));
			clr_len <= deviation_clear_out ? clr_len + CLR_W'(1) : '0;
		end
	end

	a_step_rate: assert property (@(posedge clk_sys) disable iff (!arst_n)
		step_any && !step_prev |-> since_rise >= PER_W'(PER_MIN_CYC))
		else $error("step pulses closer than the minimum period");
	a_clear_width: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$fell(deviation_clear_out) |-> clr_len == CLR_W'(CLR_CYC_P))
		else $error("deviation clear width wrong");
	a_zero_after_near: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$rose(zp_found_q) |-> $past(dog_seen_q) && $past(state_q) inside {ST_HIGH, ST_LOW})
		else $error("zero phase taken before near point");
	a_near_sampled: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state_q != ST_IDLE && kind_q == KIND_ZERO && in_s[IN_NEAR] |=> dog_seen_q)
		else $error("near point not sampled during zero return");
	a_auto_gate: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state_q == ST_IDLE && !manual_mode && !ctrl_q[CB_STANDBY] |=> state_q == ST_IDLE ||
		kind_q == KIND_COUNT)
		else $error("jog or zero return accepted outside standby");
	a_relay_start: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state_q == ST_IDLE && zret_p_q && ctrl_q[CB_STANDBY] |=> state_q == ST_CHECK)
		else $error("zero return relay ignored");
	a_hi_fixed: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state_q == ST_HIGH && DUAL_AXIS && !interp_q && frq_q > FRQ_W'(MID_HZ)
		|-> hi_q == PER_W'(HI_FIXED_CYC))
		else $error("high time not fixed above mid frequency");
	a_duty_sym: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$fell(step_any) && !(DUAL_AXIS && !interp_q && frq_q > FRQ_W'(MID_HZ))
		|-> hi_len == (per_q >> 1))
		else $error("step duty not symmetric");
	a_limit_stop: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state_q == ST_LOW && cnt_q >= per_q - hi_q - PER_W'(1) && lim_dir
		|=> state_q == ST_DONE ##1 !step_any[*2])
		else $error("drive continued into a limit");
	a_wait_done: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state_q == ST_DONE && !in_s[IN_SVDONE] |=> state_q == ST_DONE)
		else $error("drive finished without servo done");
	c_jog: cover property (@(posedge clk_sys) disable iff (!arst_n)
		kind_q == KIND_JOG && $rose(step_any));
	c_zero_ret: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(zp_found_q));
	c_clear: cover property (@(posedge clk_sys) disable iff (!arst_n) $fell(deviation_clear_out));
endmodule

// >>> verification/pospls_drive_model.sv
// drive unit model: servo status lines and step pulse measurement
module pospls_drive_model
	import pospls_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic forward_step_out,
	input wire logic reverse_step_out,
	input wire logic deviation_clear_out,
	input wire logic ready_level,
	input wire logic [7:0] settle,
	output logic servo_ready_in,
	output logic servo_done_in,
	output int fwd_cnt,
	output int rev_cnt,
	output int hi_w,
	output int lo_w,
	output int clr_w
);
	timeunit 1ns;
	timeprecision 1ps;
	logic step;
	logic [2:0] prev;
	int hi_run, lo_run, clr_run, quiet;
	////////////////////////////////////////////////////////////////////////////////
	// status lines, slow or prompt settling
	// step inputs are only counted and timed, no rate limit is modelled
	assign step = forward_step_out | reverse_step_out;
	assign servo_ready_in = ready_level;
	assign servo_done_in = (quiet >= int'(settle));
	////////////////////////////////////////////////////////////////////////////////
	// pulse counting and width measurement
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prev <= 3'h0;
			fwd_cnt <= 0;
			rev_cnt <= 0;
			hi_run <= 0;
			lo_run <= 0;
			clr_run <= 0;
			quiet <= 0;
			hi_w <= 0;
			lo_w <= 0;
			clr_w <= 0;
		end else begin
			prev <= {deviation_clear_out, reverse_step_out, forward_step_out};
			if (forward_step_out && !prev[0]) fwd_cnt <= fwd_cnt + 1;
			if (reverse_step_out && !prev[1]) rev_cnt <= rev_cnt + 1;
			hi_run <= step ? hi_run + 1 : 0;
			lo_run <= step ? 0 : lo_run + 1;
			clr_run <= deviation_clear_out ? clr_run + 1 : 0;
			if (!step && hi_run != 0) hi_w <= hi_run;
			if (step && lo_run != 0) lo_w <= lo_run;
			if (!deviation_clear_out && clr_run != 0) clr_w <= clr_run;
			quiet <= step ? 0 : (quiet < 255 ? quiet + 1 : quiet);
		end
	end
endmodule

// >>> verification/tb_pospls_top.sv
// self-checking bench of the positioning pulse block
module tb_pospls_top
	import pospls_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CLR_P = 20;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, rd;
	logic [1:0] rs;
	logic servo_ready_in, servo_done_in, forward_step_out, reverse_step_out, deviation_clear_out;
	logic zero_phase_in = 1'b0, zero_return_request = 1'b0, near_point_in = 1'b0;
	logic jog_forward_in = 1'b0, jog_reverse_in = 1'b0;
	logic forward_limit_in = 1'b0, reverse_limit_in = 1'b0;
	logic ready_level = 1'b1;
	logic [7:0] settle = 8'h03;
	int fwd_cnt, rev_cnt, hi_w, lo_w, clr_w;
	int miscompares = 0;
	int samples_checked = 0;
	always #20 clk_sys = ~clk_sys;
	pospls_top #(.DUAL_AXIS(1'b1), .CLR_CYC_P(CLR_P)) pospls_top_inst (.clk_sys, .arst_n,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .servo_ready_in,
		.servo_done_in, .zero_phase_in, .zero_return_request, .jog_forward_in, .jog_reverse_in,
		.forward_limit_in, .reverse_limit_in, .near_point_in, .forward_step_out,
		.reverse_step_out, .deviation_clear_out);
	pospls_drive_model pospls_drive_model_inst (.clk_sys, .arst_n, .forward_step_out,
		.reverse_step_out, .deviation_clear_out, .ready_level, .settle, .servo_ready_in,
		.servo_done_in, .fwd_cnt, .rev_cnt, .hi_w, .lo_w, .clr_w);
	////////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task results;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task axw(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			#1;
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = (s_axi_bvalid === 1'b1);
			rs = s_axi_bresp;
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tb);
		s_axi_bready <= 1'b0;
	endtask
	task axr(input logic [11:0] a);
		logic ta, tb;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			#1;
			ta = s_axi_arvalid & s_axi_arready;
			tb = (s_axi_rvalid === 1'b1);
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge clk_sys);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tb);
		s_axi_rready <= 1'b0;
	endtask
	task idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task t_regs;
		chk("clear after reset", deviation_clear_out, 1'b0);
		axr(OFS_MAXSPD);
		chk("max speed reset", rd, 32'h000186A0);
		axr(OFS_JOGSPD);
		chk("jog speed reset", rd, 32'h000003E8);
		axr(OFS_CTRL);
		chk("control reset", rd, 32'h00000000);
		axr(12'h020);
		chk("unmapped read", rd, 32'h00000000);
		chk("unmapped read resp", rs, RESP_SLVERR);
		axw(12'h020, 32'h00000001);
		chk("unmapped write resp", rs, RESP_SLVERR);
	endtask
	task t_drive(input logic [31:0] ctrl, input logic [31:0] freq, input int hi, input int lo);
		int f0, r0;
		f0 = fwd_cnt;
		r0 = rev_cnt;
		axw(OFS_MAXSPD, freq);
		axw(OFS_COUNT, 32'h00000003);
		axw(OFS_CTRL, ctrl | 32'h00000100);
		wait (fwd_cnt + rev_cnt == f0 + r0 + 3);
		idle(300);
		chk("pulses", ctrl[CB_REVERSE] ? rev_cnt - r0 : fwd_cnt - f0, 3);
		chk("wrong direction", ctrl[CB_REVERSE] ? fwd_cnt - f0 : rev_cnt - r0, 0);
		chk("high time", hi_w, hi);
		chk("low time", lo_w, lo);
		axr(OFS_STAT);
		chk("busy done", rd[1:0], 2'h2);
	endtask
	task t_halt;
		int n0;
		axw(OFS_COUNT, 32'h00000064);
		axw(OFS_CTRL, 32'h00000100);
		idle(600);
		forward_limit_in <= 1'b1;
		idle(600);
		n0 = fwd_cnt;
		idle(600);
		chk("limit stops drive", fwd_cnt, n0);
		axr(OFS_STAT);
		chk("limit fault", rd[2:0], 3'h6);
		forward_limit_in <= 1'b0;
		idle(10);
		axw(OFS_CTRL, 32'h00000100);
		idle(600);
		axw(OFS_CTRL, 32'h00000200);
		idle(600);
		n0 = fwd_cnt;
		idle(600);
		chk("stop ends drive", fwd_cnt, n0);
	endtask
	task t_refuse;
		int n0;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys);
			ready_level <= (i != 0);
			forward_limit_in <= (i == 1);
			reverse_limit_in <= (i == 2);
			idle(10);
			n0 = fwd_cnt + rev_cnt;
			axw(OFS_CTRL, (i == 2) ? 32'h00000102 : 32'h00000100);
			idle(400);
			chk("refused pulses", fwd_cnt + rev_cnt, n0);
			axr(OFS_STAT);
			chk("fault flag", rd[2], 1'b1);
		end
		forward_limit_in <= 1'b0;
		reverse_limit_in <= 1'b0;
		ready_level <= 1'b1;
		idle(10);
	endtask
	task t_jog;
		int f0, r0;
		axw(OFS_JOGSPD, 32'd100000);
		axw(OFS_MAXSPD, 32'd25000);
		axw(OFS_CTRL, 32'h00000001);
		f0 = fwd_cnt;
		jog_forward_in <= 1'b1;
		idle(700);
		jog_forward_in <= 1'b0;
		idle(1200);
		chk("jog high time", hi_w, 125);
		chk("manual jog moved", fwd_cnt > f0, 1'b1);
		axw(OFS_CTRL, 32'h00000000);
		r0 = rev_cnt;
		jog_reverse_in <= 1'b1;
		idle(700);
		chk("auto jog refused", rev_cnt, r0);
		axw(OFS_CTRL, 32'h00000008);
		idle(700);
		jog_reverse_in <= 1'b0;
		idle(1200);
		chk("standby jog moved", rev_cnt > r0, 1'b1);
	endtask
	task t_zero;
		int n0;
		axw(OFS_MAXSPD, 32'd100000);
		axw(OFS_CTRL, 32'h00000008);
		n0 = fwd_cnt + rev_cnt;
		axw(OFS_CTRL, 32'h00000408);
		idle(400);
		chk("relay zero return", fwd_cnt + rev_cnt > n0, 1'b1);
		zero_phase_in <= 1'b1;
		idle(10);
		zero_phase_in <= 1'b0;
		n0 = fwd_cnt + rev_cnt;
		idle(600);
		chk("phase before near", fwd_cnt + rev_cnt > n0, 1'b1);
		near_point_in <= 1'b1;
		idle(300);
		axr(OFS_STAT);
		chk("near seen", rd[4:3], 2'h1);
		zero_phase_in <= 1'b1;
		idle(10);
		zero_phase_in <= 1'b0;
		idle(800);
		n0 = fwd_cnt + rev_cnt;
		idle(400);
		chk("return stopped", fwd_cnt + rev_cnt, n0);
		chk("clear width", clr_w, CLR_P);
		axr(OFS_STAT);
		chk("return done", rd[1:0], 2'h2);
		near_point_in <= 1'b0;
	endtask
	task t_clear;
		axw(OFS_CTRL, 32'h00000800);
		axr(OFS_STAT);
		chk("clear active", rd[5], 1'b1);
		idle(60);
		chk("clear ended", deviation_clear_out, 1'b0);
		chk("clear width", clr_w, CLR_P);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial begin
		idle(5);
		arst_n <= 1'b1;
		t_regs;
		t_drive(32'h0, 32'd100000, 125, 125);
		settle <= 8'hC8;
		t_drive(32'h2, 32'd150000, 63, 103);
		t_drive(32'h0, 32'd200000, 63, 62);
		t_drive(32'h0, 32'd250000, 63, 62);
		settle <= 8'h03;
		t_drive(32'h4, 32'd200000, 125, 125);
		t_halt;
		t_refuse;
		t_jog;
		t_zero;
		t_clear;
		results;
	end
	initial begin
		idle(80000);
		miscompares++;
		results;
	end
endmodule
